// ==== rtl/srro_pkg.sv ====
// Shared constants, opcodes and state types for the stack, repeat and
// return execution block.
// Assumes a single core clock and a synchronous active-high reset.
package srro_pkg;

    // ==================================================================
    // Widths
    // ==================================================================
    localparam int unsigned WORD_W = 16;
    localparam int unsigned WSEL_W = 4;
    localparam int unsigned CYC_W = 3;

    // ==================================================================
    // Cycle counts per instruction
    // ==================================================================
    localparam logic [2:0] CYC_SINGLE = 3'h1;
    localparam logic [2:0] CYC_DOUBLE = 3'h2;
    localparam logic [2:0] CYC_RETURN = 3'h6;
    localparam logic [2:0] CYC_RETURN_SHORT = 3'h5;
    localparam logic [2:0] CYC_SFR_EXTRA = 3'h1;

    // ==================================================================
    // Literal fields, power-save selection and word reset value
    // ==================================================================
    localparam int unsigned REP_LIT_W = 15;
    localparam int unsigned RET_LIT_W = 10;
    localparam logic PSAVE_SEL_IDLE = 1'b1;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ==================================================================
    // Opcodes and states
    // ==================================================================
    typedef enum logic [3:0] {
        OP_NOP = 4'b0000,
        OP_POP_F = 4'b0001,
        OP_POP_W = 4'b0010,
        OP_POP_D = 4'b0011,
        OP_PUSH_F = 4'b0100,
        OP_PUSH_W = 4'b0101,
        OP_PUSH_D = 4'b0110,
        OP_PSAVE = 4'b0111,
        OP_REP_LIT = 4'b1000,
        OP_REP_REG = 4'b1001,
        OP_RET_LIT = 4'b1010,
        OP_OTHER = 4'b1011
    } srro_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } srro_state_t;

    typedef struct packed {
        srro_state_t st;
        srro_op_t op;
        logic [3:0] wsel;
        logic [15:0] faddr;
        logic [15:0] nxt;
        logic sfr;
        logic [15:0] sp;
        logic busy;
        logic done;
        logic freg_we;
        logic [15:0] freg_addr;
        logic [15:0] freg_wdata;
        logic wreg_we;
        logic [3:0] wreg_sel;
        logic [15:0] wreg_wdata;
        logic stk_we;
        logic [15:0] stk_addr;
        logic [15:0] stk_wdata;
        logic sleep_req;
        logic idle_req;
        logic watchdog_timeout_flag;
        logic slp;
        logic stack_frame_active_flag;
        logic ret_req;
        logic rep_active;
    } srro_exec_st_t;

    typedef struct packed {
        logic [15:0] count;
    } srro_cnt_st_t;

endpackage

// ==== rtl/srro_down_cnt.sv ====
// Loadable down counter used for multi-cycle sequencing and repeat counts.
// Assumes one clock and a synchronous active-high reset.
module srro_down_cnt #(
    parameter int unsigned W = 16
) (
    input wire logic ref_clk_in,  // Core clock.
    input wire logic srst_in,  // Synchronous reset, active high.
    input wire logic load_in,  // Load the start value.
    input wire logic [W-1:0] load_val_in,  // Start value.
    input wire logic dec_in,  // Count down by one.
    output logic [W-1:0] count_out,  // Current count, registered.
    output logic zero_out  // Count is zero.
);
    srro_pkg::srro_cnt_st_t q, d;

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        d = q;
        if (load_in) begin
            d.count = 16'(load_val_in);
        end else if (dec_in && q.count[W-1:0] != '0) begin
            d.count = 16'(q.count[W-1:0] - W'(1));
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_out = q.count[W-1:0];
    assign zero_out = (q.count[W-1:0] == '0);
endmodule

// ==== rtl/srro_exec.sv ====
// Execution of stack push/pop, power-save entry, hardware repeat and
// return-with-literal for a 16-bit core.
// Assumes the decoder presents one decoded operation with its operands and
// register read data, and that stack_top_word_in is the memory word just
// below stack_ptr_out.

module srro_exec #(
    parameter int unsigned SP_RESET = 0
) (
    input wire logic ref_clk_in,  // Core clock, 50 MHz.
    input wire logic srst_in,  // Synchronous reset, active high.
    input wire logic op_valid_in,  // Decoded operation offered.
    input wire srro_pkg::srro_op_t op_code_in,  // Operation code.
    input wire logic [15:0] op_freg_addr_in,  // File register address.
    input wire logic [3:0] op_wreg_sel_in,  // named_work_reg select.
    input wire logic [15:0] op_lit_in,  // Literal operand.
    input wire logic op_sfr_in,  // Operand is a peripheral register.
    input wire logic ret_short_in,  // Return takes the short count.
    input wire logic [15:0] freg_rdata_in,  // File register read data.
    input wire logic [15:0] wreg_rdata_in,  // Selected register data.
    input wire logic [15:0] wreg_rdata_nxt_in,  // Next register data.
    input wire logic [15:0] stack_top_word_in,  // Word below pointer.
    input wire logic wdt_timeout_in,  // Watchdog timed out.
    input wire logic sfa_set_in,  // A stack frame was opened.
    output logic busy_out,  // Multi-cycle operation in progress.
    output logic done_out,  // Operation finished, one pulse.
    output logic [15:0] stack_ptr_out,  // Stack pointer, word index.
    output logic freg_we_out,  // File register write pulse.
    output logic [15:0] freg_addr_out,  // File register write address.
    output logic [15:0] freg_wdata_out,  // File register write data.
    output logic wreg_we_out,  // Working register write pulse.
    output logic [3:0] wreg_sel_out,  // Working register written.
    output logic [15:0] wreg_wdata_out,  // Working register data.
    output logic stack_we_out,  // Stack write pulse.
    output logic [15:0] stack_addr_out,  // Stack write word index.
    output logic [15:0] stack_wdata_out,  // Stack write data.
    output logic sleep_req_out,  // Enter sleep, one pulse.
    output logic idle_req_out,  // Enter idle, one pulse.
    output logic watchdog_timeout_flag_out,  // Watchdog timeout status.
    output logic sleep_flag_out,  // Sleep status.
    output logic stack_frame_active_flag_out,  // Frame active status.
    output logic return_req_out,  // Return to caller, one pulse.
    output logic repeat_active_out,  // Hold the fetch address.
    output logic [15:0] repeat_count_out  // Repeats still to run.
);
    srro_pkg::srro_exec_st_t q, d;
    logic cyc_load, cyc_dec, rep_load, rep_dec, rep_zero;
    logic [2:0] cyc_val, cyc_cnt, total_c;
    logic [15:0] rep_val;

    srro_down_cnt #(.W(srro_pkg::CYC_W)) u_cyc (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .load_in(cyc_load),
        .load_val_in(cyc_val),
        .dec_in(cyc_dec),
        .count_out(cyc_cnt),
        .zero_out()
    );

    srro_down_cnt #(.W(srro_pkg::WORD_W)) u_rep (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .load_in(rep_load),
        .load_val_in(rep_val),
        .dec_in(rep_dec),
        .count_out(repeat_count_out),
        .zero_out(rep_zero)
    );

    // ==================================================================
    // Next state
    // ==================================================================
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.freg_we = 1'b0;
        d.wreg_we = 1'b0;
        d.stk_we = 1'b0;
        d.sleep_req = 1'b0;
        d.idle_req = 1'b0;
        d.ret_req = 1'b0;
        cyc_load = 1'b0;
        cyc_dec = 1'b0;
        rep_load = 1'b0;
        rep_dec = 1'b0;
        rep_val = srro_pkg::WORD_RST;
        total_c = srro_pkg::CYC_SINGLE;
        case (op_code_in)
            srro_pkg::OP_POP_D, srro_pkg::OP_PUSH_D: begin
                total_c = srro_pkg::CYC_DOUBLE;
            end
            srro_pkg::OP_RET_LIT: begin
                total_c = ret_short_in ? srro_pkg::CYC_RETURN_SHORT
                                       : srro_pkg::CYC_RETURN;
            end
            srro_pkg::OP_PUSH_F, srro_pkg::OP_OTHER: begin
                if (op_sfr_in) begin
                    total_c = srro_pkg::CYC_SINGLE + srro_pkg::CYC_SFR_EXTRA;
                end
            end
            default: begin
                total_c = srro_pkg::CYC_SINGLE;
            end
        endcase
        cyc_val = total_c - srro_pkg::CYC_SINGLE;
        case (q.st)
            srro_pkg::ST_IDLE: begin
                if (op_valid_in) begin
                    d.op = op_code_in;
                    d.wsel = op_wreg_sel_in;
                    d.faddr = op_freg_addr_in;
                    d.nxt = wreg_rdata_nxt_in;
                    d.sfr = op_sfr_in;
                    case (op_code_in)
                        srro_pkg::OP_POP_F: begin
                            d.freg_we = 1'b1;
                            d.freg_addr = op_freg_addr_in;
                            d.freg_wdata = stack_top_word_in;
                            d.sp = q.sp - 16'h0001;
                        end
                        srro_pkg::OP_POP_W, srro_pkg::OP_POP_D: begin
                            // The upper register of a pair comes off first.
                            d.wreg_we = 1'b1;
                            d.wreg_sel = (op_code_in == srro_pkg::OP_POP_D)
                                ? op_wreg_sel_in + 4'h1 : op_wreg_sel_in;
                            d.wreg_wdata = stack_top_word_in;
                            d.sp = q.sp - 16'h0001;
                        end
                        srro_pkg::OP_PUSH_F: begin
                            if (!op_sfr_in) begin
                                d.stk_we = 1'b1;
                                d.stk_addr = q.sp;
                                d.stk_wdata = freg_rdata_in;
                                d.sp = q.sp + 16'h0001;
                            end
                        end
                        srro_pkg::OP_PUSH_W, srro_pkg::OP_PUSH_D: begin
                            d.stk_we = 1'b1;
                            d.stk_addr = q.sp;
                            d.stk_wdata = wreg_rdata_in;
                            d.sp = q.sp + 16'h0001;
                        end
                        srro_pkg::OP_PSAVE: begin
                            // Entry clears the watchdog timeout status.
                            d.watchdog_timeout_flag = 1'b0;
                            if (op_lit_in[0] == srro_pkg::PSAVE_SEL_IDLE) begin
                                d.idle_req = 1'b1;
                            end else begin
                                d.sleep_req = 1'b1;
                                d.slp = 1'b1;
                            end
                        end
                        srro_pkg::OP_REP_LIT: begin
                            rep_load = 1'b1;
                            rep_val = {1'b0, op_lit_in[14:0]};
                            d.rep_active = 1'b1;
                        end
                        srro_pkg::OP_REP_REG: begin
                            rep_load = 1'b1;
                            rep_val = wreg_rdata_in;
                            d.rep_active = 1'b1;
                        end
                        srro_pkg::OP_RET_LIT: begin
                            d.wreg_we = 1'b1;
                            d.wreg_sel = op_wreg_sel_in;
                            d.wreg_wdata = {6'h00, op_lit_in[9:0]};
                        end
                        default: begin
                        end
                    endcase
                    if (cyc_val != 3'h0) begin
                        cyc_load = 1'b1;
                        d.st = srro_pkg::ST_EXEC;
                        d.busy = 1'b1;
                    end else begin
                        d.done = 1'b1;
                    end
                end
            end
            srro_pkg::ST_EXEC: begin
                cyc_dec = 1'b1;
                if (cyc_cnt == 3'h1) begin
                    d.st = srro_pkg::ST_IDLE;
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    case (q.op)
                        srro_pkg::OP_POP_D: begin
                            d.wreg_we = 1'b1;
                            d.wreg_sel = q.wsel;
                            d.wreg_wdata = stack_top_word_in;
                            d.sp = q.sp - 16'h0001;
                        end
                        srro_pkg::OP_PUSH_D: begin
                            d.stk_we = 1'b1;
                            d.stk_addr = q.sp;
                            d.stk_wdata = q.nxt;
                            d.sp = q.sp + 16'h0001;
                        end
                        srro_pkg::OP_PUSH_F: begin
                            d.stk_we = 1'b1;
                            d.stk_addr = q.sp;
                            d.stk_wdata = freg_rdata_in;
                            d.sp = q.sp + 16'h0001;
                        end
                        srro_pkg::OP_RET_LIT: begin
                            d.ret_req = 1'b1;
                            d.stack_frame_active_flag = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                d.st = srro_pkg::ST_IDLE;
            end
        endcase
        // Each finished repeated instruction uses up one pass.
        if (d.done && q.rep_active && d.op != srro_pkg::OP_REP_LIT &&
            d.op != srro_pkg::OP_REP_REG) begin
            if (rep_zero) begin
                d.rep_active = 1'b0;
            end else begin
                rep_dec = 1'b1;
            end
        end
        // Hardware events win over a clear in the same cycle.
        if (wdt_timeout_in) begin
            d.watchdog_timeout_flag = 1'b1;
        end
        if (sfa_set_in) begin
            d.stack_frame_active_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            q <= '0;
            q.sp <= 16'(SP_RESET);
        end else begin
            q <= d;
        end
    end

    assign busy_out = q.busy;
    assign done_out = q.done;
    assign stack_ptr_out = q.sp;
    assign freg_we_out = q.freg_we;
    assign freg_addr_out = q.freg_addr;
    assign freg_wdata_out = q.freg_wdata;
    assign wreg_we_out = q.wreg_we;
    assign wreg_sel_out = q.wreg_sel;
    assign wreg_wdata_out = q.wreg_wdata;
    assign stack_we_out = q.stk_we;
    assign stack_addr_out = q.stk_addr;
    assign stack_wdata_out = q.stk_wdata;
    assign sleep_req_out = q.sleep_req;
    assign idle_req_out = q.idle_req;
    assign watchdog_timeout_flag_out = q.watchdog_timeout_flag;
    assign sleep_flag_out = q.slp;
    assign stack_frame_active_flag_out = q.stack_frame_active_flag;
    assign return_req_out = q.ret_req;
    assign repeat_active_out = q.rep_active;

    // ==================================================================
    // Checks
    // ==================================================================
    a_pop_file_one: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_POP_F) |=>
        freg_we_out && done_out && !busy_out &&
        freg_wdata_out == $past(stack_top_word_in))
        else $error("file pop not done in one cycle");
    a_pop_work_flags: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in && !wdt_timeout_in &&
         op_code_in == srro_pkg::OP_POP_W) |=>
        wreg_we_out && done_out && $stable(watchdog_timeout_flag_out))
        else $error("register pop wrong or touched flags");
    a_pop_double_two: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_POP_D) |=>
        wreg_we_out && busy_out ##1 wreg_we_out && done_out &&
        wreg_sel_out == $past(wreg_sel_out) - 4'h1)
        else $error("double pop not two cycles");
    a_push_file_one: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in && !op_sfr_in &&
         op_code_in == srro_pkg::OP_PUSH_F) |=>
        stack_we_out && done_out && stack_wdata_out == $past(freg_rdata_in))
        else $error("file push not done in one cycle");
    a_push_work_one: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_PUSH_W) |=>
        stack_we_out && done_out && stack_wdata_out == $past(wreg_rdata_in))
        else $error("register push wrong");
    a_push_double_pair: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_PUSH_D) |=>
        stack_we_out ##1 stack_we_out && done_out &&
        stack_addr_out == $past(stack_addr_out) + 16'h0001)
        else $error("double push not a two-cycle pair");
    a_psave_mode_sel: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_PSAVE) |=>
        (sleep_req_out != idle_req_out) &&
        idle_req_out == $past(op_lit_in[0]) &&
        (idle_req_out || sleep_flag_out))
        else $error("power save mode or flag wrong");
    a_repeat_lit_load: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_REP_LIT) |=>
        repeat_active_out && done_out &&
        repeat_count_out == {1'b0, $past(op_lit_in[14:0])})
        else $error("literal repeat count wrong");
    a_repeat_reg_load: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in &&
         op_code_in == srro_pkg::OP_REP_REG) |=>
        repeat_active_out && repeat_count_out == $past(wreg_rdata_in))
        else $error("register repeat count wrong");
    a_return_six_cycles: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in && !ret_short_in &&
         op_code_in == srro_pkg::OP_RET_LIT) |=>
        busy_out [*5] ##1 (return_req_out && done_out && !busy_out))
        else $error("return not six cycles");
    a_sfr_extra_cycle: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (q.st == srro_pkg::ST_IDLE && op_valid_in && op_sfr_in &&
         op_code_in == srro_pkg::OP_PUSH_F) |=>
        busy_out && !stack_we_out ##1 stack_we_out && done_out)
        else $error("peripheral read missed its extra cycle");
    a_sp_push_step: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        stack_we_out |-> stack_ptr_out == stack_addr_out + 16'h0001)
        else $error("pointer not one past the pushed word");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the stack, repeat and return execution block.
// Assumes one 50 MHz clock; the bench stands in for the core and stack memory.
module testbench;
timeunit 1ns;
timeprecision 1ps;
// ===================================================================
// Stimulus and design
// ===================================================================
logic ref_clk_in = 0, srst_in = 1, op_valid_in = 0, op_sfr_in = 0;
logic ret_short_in = 0, wdt_timeout_in = 0, sfa_set_in = 0;
srro_pkg::srro_op_t op_code_in = srro_pkg::OP_NOP;
logic [15:0] op_freg_addr_in = 0, op_lit_in = 0, freg_rdata_in = 0;
logic [15:0] wreg_rdata_in = 0, wreg_rdata_nxt_in = 0, stack_top_word_in;
logic [3:0] op_wreg_sel_in = 0, wreg_sel_out;
logic busy_out, done_out, freg_we_out, wreg_we_out, stack_we_out;
logic sleep_req_out, idle_req_out, watchdog_timeout_flag_out;
logic sleep_flag_out, stack_frame_active_flag_out, return_req_out;
logic repeat_active_out;
logic [15:0] stack_ptr_out, freg_addr_out, freg_wdata_out, wreg_wdata_out;
logic [15:0] stack_addr_out, stack_wdata_out, repeat_count_out;
logic [15:0] mem [16];
logic [19:0] wq [$];
logic e_wd = 0, e_slp = 0, e_sfa = 0, l0;
int fail_count = 0, checks = 0, seed = 82, n, k, cnt, exp_sp = 0;
int stk [$];
srro_exec #(.SP_RESET(0)) srro_exec_inst (.*);
always #10 ref_clk_in = ~ref_clk_in;
// Stack memory answers combinationally from the word below the pointer.
assign stack_top_word_in = mem[stack_ptr_out[3:0] - 4'h1];
always @(posedge ref_clk_in) begin
    if (stack_we_out === 1'b1) mem[stack_addr_out[3:0]] <= stack_wdata_out;
    if (wreg_we_out === 1'b1) wq.push_back({wreg_sel_out, wreg_wdata_out});
end
// ===================================================================
// Tasks
// ===================================================================
task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
        fail_count++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
endtask
// Two spare edges before each op let the last stack write land in memory.
task automatic issue(input srro_pkg::srro_op_t op, input int nc,
                     input logic sfr, input logic [15:0] lit);
    repeat (2) @(posedge ref_clk_in);
    wq.delete();
    op_valid_in <= 1'b1;
    op_code_in <= op;
    op_sfr_in <= sfr;
    op_lit_in <= lit;
    op_wreg_sel_in <= 4'($unsigned($random(seed)) % 15);
    op_freg_addr_in <= 16'($random(seed));
    freg_rdata_in <= 16'($random(seed));
    wreg_rdata_in <= (op == srro_pkg::OP_REP_REG) ? lit : 16'($random(seed));
    wreg_rdata_nxt_in <= 16'($random(seed));
    ret_short_in <= (nc == 5);
    @(posedge ref_clk_in);
    op_valid_in <= 1'b0;
    n = 1;
    @(negedge ref_clk_in);
    while (done_out !== 1'b1 && n < 9) begin
        @(negedge ref_clk_in);
        n++;
    end
    chk("cycles", n, nc);
endtask
task automatic final_report;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
// ===================================================================
// Sequence
// ===================================================================
initial begin
    #400000;
    fail_count++;
    final_report();
end
initial begin
    repeat (12) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    wdt_timeout_in <= 1'b1;
    sfa_set_in <= 1'b1;
    @(posedge ref_clk_in);
    wdt_timeout_in <= 1'b0;
    sfa_set_in <= 1'b0;
    e_wd = 1;
    e_sfa = 1;
    @(negedge ref_clk_in);
    for (k = 0; k < 80; k++) begin
        chk("sp", stack_ptr_out, 16'(exp_sp));
        chk("flags", {watchdog_timeout_flag_out, sleep_flag_out,
            stack_frame_active_flag_out}, {e_wd, e_slp, e_sfa});
        cnt = $unsigned($random(seed)) % 8;
        if (stk.size() > 12 && cnt < 3) cnt = 3;
        if (stk.size() < 2 && cnt > 2 && cnt < 6) cnt = 1;
        case (cnt)
            0: begin
                issue(srro_pkg::OP_PUSH_W, 1, 0, 16'h0000);
                chk("push", {stack_addr_out, stack_wdata_out}, {16'(exp_sp), wreg_rdata_in});
                stk.push_back(wreg_rdata_in);
                exp_sp++;
            end
            1: begin
                issue(srro_pkg::OP_PUSH_D, 2, 0, 16'h0000);
                chk("push pair", {stack_addr_out, stack_wdata_out}, {16'(exp_sp + 1), wreg_rdata_nxt_in});
                stk.push_back(wreg_rdata_in);
                stk.push_back(wreg_rdata_nxt_in);
                exp_sp += 2;
            end
            2: begin
                l0 = 1'($random(seed));
                issue(srro_pkg::OP_PUSH_F, 1 + l0, l0, 16'h0000);
                chk("push file", stack_wdata_out, freg_rdata_in);
                stk.push_back(freg_rdata_in);
                exp_sp++;
            end
            3: begin
                issue(srro_pkg::OP_POP_W, 1, 0, 16'h0000);
                chk("pop", {wreg_we_out, wreg_sel_out, wreg_wdata_out}, {1'b1, op_wreg_sel_in, 16'(stk.pop_back())});
                exp_sp--;
            end
            4: begin
                issue(srro_pkg::OP_POP_D, 2, 0, 16'h0000);
                chk("pop hi", wq[0], {op_wreg_sel_in + 4'h1, 16'(stk.pop_back())});
                chk("pop lo", {wreg_we_out, wreg_sel_out, wreg_wdata_out}, {1'b1, op_wreg_sel_in, 16'(stk.pop_back())});
                exp_sp -= 2;
            end
            5: begin
                issue(srro_pkg::OP_POP_F, 1, 0, 16'h0000);
                chk("pop file", {freg_addr_out, freg_wdata_out}, {op_freg_addr_in, 16'(stk.pop_back())});
                exp_sp--;
            end
            6: begin
                issue(srro_pkg::OP_PSAVE, 1, 0, 16'($random(seed)));
                l0 = op_lit_in[0];
                chk("save req", {sleep_req_out, idle_req_out}, {~l0, l0});
                e_wd = 0;
                e_slp = e_slp | ~l0;
            end
            default: begin
                issue(srro_pkg::OP_RET_LIT, ($random(seed) & 1) ? 5 : 6, 0, 16'($random(seed)));
                chk("ret lit", wq[0], {op_wreg_sel_in, 6'h00, op_lit_in[9:0]});
                chk("ret req", return_req_out, 1'b1);
                e_sfa = 0;
            end
        endcase
    end
    for (k = 0; k < 4; k++) begin
        cnt = $unsigned($random(seed)) % 4;
        issue(k[0] ? srro_pkg::OP_REP_REG : srro_pkg::OP_REP_LIT, 1, 0, 16'(cnt));
        chk("rep", {repeat_active_out, repeat_count_out}, {1'b1, 16'(cnt)});
        repeat (cnt + 1) begin
            chk("rep on", repeat_active_out, 1'b1);
            issue(k[1] ? srro_pkg::OP_OTHER : srro_pkg::OP_NOP, 1 + k[1], k[1], 16'h0000);
        end
        chk("rep off", repeat_active_out, 1'b0);
    end
    final_report();
end
endmodule
